// ### inc/fault_cfg_pkg.sv
// Constants, field layout and encodings of the recoverable fault block
// Behaviour
// - Two-bit field picks capture channel 0 to 3 for a fault capture.
// - Halt field: 0 off, 1 hardware, 2 software, 3 non-recoverable.
// - Restart bit set makes a fault restart the timer; clear does nothing.
// - Masking starts at ramp start, rising, falling or every output toggle.
// - Output-level gating ignores the fault while compare output is low.
// - Keeper 0 releases with input; keeper 1 holds until cycle end.
// - Source: off, event, inverted event, other channel state last period.
// - Bit 2 reads zero and software writes zero to it.
// - Fault ignored for masking time prescaled ticks after the chosen edge.
// - Masking prescale bit multiplies masking time by 64.
// - Three-bit capture action encodes none through capture with index.
// - Bits 31 to 28 read zero and software writes zero to them.
// - Channel B register has channel A's layout and resets to zero.
// - Channel A register sits at 0x0c and resets to zero.
package fault_cfg_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam int          ADDR_W            = 8;
  localparam logic [7:0]  CONTROL_OFFSET    = 8'h00;
  localparam logic [7:0]  IRQ_STATUS_OFFSET = 8'h04;
  localparam logic [7:0]  IRQ_MASK_OFFSET   = 8'h08;
  localparam logic [7:0]  FAULT_A_OFFSET    = 8'h0c;
  localparam logic [7:0]  FAULT_B_OFFSET    = 8'h10;
  localparam logic [31:0] FAULT_RESET       = 32'h0000_0000;
  localparam logic [31:0] FAULT_WRITE_MASK  = 32'h0fff_fffb;

  // ***************************************************************
  // Field layout
  // ***************************************************************
  localparam int SRC_LSB     = 0;
  localparam int KEEP_BIT    = 3;
  localparam int OUTPUT_LEVEL_GATING_BIT    = 4;
  localparam int MSTART_LSB  = 5;
  localparam int RESTART_BIT = 7;
  localparam int HALT_LSB    = 8;
  localparam int CHAN_LSB    = 10;
  localparam int CAPT_LSB    = 12;
  localparam int MPRESC_BIT  = 15;
  localparam int MTIME_LSB   = 16;
  localparam int FILTER_LSB  = 24;
  localparam int ENABLE_BIT  = 0;
  localparam int LOCK_BIT    = 1;
  localparam int CH_NUM      = 2;
  localparam int FLAG_W      = 4;
  localparam int MCNT_W      = 14;
  localparam int MPRESC_SHIFT = 6;

  // ***************************************************************
  // Encodings
  // ***************************************************************
  typedef enum logic [1:0] {
    HALT_OFF, HALT_HW, HALT_SW, HALT_NR
  } halt_mode_t;
  typedef enum logic [1:0] {
    MSTART_RAMP, MSTART_RISE, MSTART_FALL, MSTART_BOTH
  } mask_start_t;
  typedef enum logic [1:0] {
    SRC_OFF, SRC_EVENT, SRC_INVERT, SRC_OTHER
  } source_t;
  typedef enum logic [2:0] {
    CAPT_NONE, CAPT_ON_FAULT, CAPT_MIN, CAPT_MAX,
    CAPT_LOC_MIN, CAPT_LOC_MAX, CAPT_LOC_BOTH, CAPT_WITH_INDEX
  } capture_action_t;

endpackage : fault_cfg_pkg

// ### hw/recoverable_fault.sv
// Two recoverable fault channels with configuration registers
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
module recoverable_fault
  import fault_cfg_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wr_data,
  input  wire logic              wr_strobe,
  input  wire logic              rd_strobe,
  output logic      [31:0]       rd_data,
  output logic                   irq,
  input  wire logic [1:0]        fault_event_input,
  input  wire logic [1:0]        compare_output_level,
  input  wire logic              ramp_start,
  input  wire logic              cycle_end,
  input  wire logic              timer_tick,
  output logic      [1:0]        fault_state,
  output logic      [1:0]        halt_hw,
  output logic      [1:0]        halt_sw,
  output logic      [1:0]        halt_nonrecoverable,
  output logic      [1:0]        restart_pulse,
  output logic      [1:0]        capture_pulse,
  output logic      [3:0]        capture_channel_choice,
  output logic      [5:0]        capture_action
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [CH_NUM-1:0][31:0]       cfg;
    logic                          enable;
    logic                          lock;
    logic [FLAG_W-1:0]             flag;
    logic [FLAG_W-1:0]             mask;
    logic [31:0]                   rd_data;
    logic                          irq;
    logic [CH_NUM-1:0]             sync1;
    logic [CH_NUM-1:0]             sync2;
    logic [CH_NUM-1:0]             filt;
    logic [CH_NUM-1:0][3:0]        fcnt;
    logic [CH_NUM-1:0]             cmp_prev;
    logic [CH_NUM-1:0][MCNT_W-1:0] mcnt;
    logic [CH_NUM-1:0]             state;
    logic [CH_NUM-1:0]             alt;
    logic [CH_NUM-1:0]             halt_hw;
    logic [CH_NUM-1:0]             halt_sw;
    logic [CH_NUM-1:0]             halt_nr;
    logic [CH_NUM-1:0]             restart;
    logic [CH_NUM-1:0]             capture;
    logic [CH_NUM-1:0][1:0]        cap_chan;
    logic [CH_NUM-1:0][2:0]        cap_act;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb
  begin
    logic [31:0]       c;
    logic [FLAG_W-1:0] set;
    logic              wr_fault;
    logic              trig;
    logic              raw;
    logic              gated;
    logic              cur;
    logic [MCNT_W-1:0] mlen;
    c        = '0;
    set      = '0;
    wr_fault = 1'b0;
    trig     = 1'b0;
    raw      = 1'b0;
    gated    = 1'b0;
    cur      = 1'b0;
    mlen     = '0;
    s_d      = s_q;

    s_d.sync1 = fault_event_input;
    s_d.sync2 = s_q.sync1;
    s_d.cmp_prev = compare_output_level;

    wr_fault = wr_strobe && !s_q.enable && !s_q.lock;

    for (int ch = 0; ch < CH_NUM; ch++)
    begin
      c = s_q.cfg[ch];

      // Glitch filter on the synchronised event input
      if (s_q.sync2[ch] == s_q.filt[ch])
      begin
        s_d.fcnt[ch] = '0;
      end
      else if (s_q.fcnt[ch] >= c[FILTER_LSB +: 4])
      begin
        s_d.filt[ch] = s_q.sync2[ch];
        s_d.fcnt[ch] = '0;
      end
      else
      begin
        s_d.fcnt[ch] = s_q.fcnt[ch] + 4'h1;
      end

      // Masking window start point
      case (mask_start_t'(c[MSTART_LSB +: 2]))
        MSTART_RAMP: trig = ramp_start;
        MSTART_RISE: trig = compare_output_level[ch] && !s_q.cmp_prev[ch];
        MSTART_FALL: trig = !compare_output_level[ch] && s_q.cmp_prev[ch];
        MSTART_BOTH: trig = compare_output_level[ch] != s_q.cmp_prev[ch];
        default:     trig = 1'b0;
      endcase

      mlen = {{(MCNT_W-8){1'b0}}, c[MTIME_LSB +: 8]};
      if (c[MPRESC_BIT])
      begin
        mlen = mlen << MPRESC_SHIFT;
      end

      if (trig)
      begin
        s_d.mcnt[ch] = mlen;
      end
      else if (timer_tick && s_q.mcnt[ch] != '0)
      begin
        s_d.mcnt[ch] = s_q.mcnt[ch] - {{(MCNT_W-1){1'b0}}, 1'b1};
      end

      // Fault source selection
      case (source_t'(c[SRC_LSB +: 2]))
        SRC_OFF:    raw = 1'b0;
        SRC_EVENT:  raw = s_q.filt[ch];
        SRC_INVERT: raw = !s_q.filt[ch];
        SRC_OTHER:  raw = s_q.alt[ch];
        default:    raw = 1'b0;
      endcase

      gated = raw
        && !(trig && mlen != '0)
        && s_q.mcnt[ch] == '0
        && !(c[OUTPUT_LEVEL_GATING_BIT] && !compare_output_level[ch]);

      // Fault state with optional hold to the end of the cycle
      if (!c[KEEP_BIT])
      begin
        cur = gated;
      end
      else if (cycle_end)
      begin
        cur = gated;
      end
      else
      begin
        cur = s_q.state[ch] || gated;
      end
      s_d.state[ch] = cur;

      // Other channel's state sampled at the end of each period
      if (cycle_end)
      begin
        s_d.alt[ch] = s_q.state[CH_NUM-1-ch];
      end

      // Halt actions
      s_d.halt_hw[ch] = cur
        && halt_mode_t'(c[HALT_LSB +: 2]) == HALT_HW;
      s_d.halt_sw[ch] = cur
        && halt_mode_t'(c[HALT_LSB +: 2]) == HALT_SW;
      s_d.halt_nr[ch] = cur
        && halt_mode_t'(c[HALT_LSB +: 2]) == HALT_NR;

      // Actions on the onset of a fault
      s_d.restart[ch] = cur && !s_q.state[ch] && c[RESTART_BIT];
      s_d.capture[ch] = cur && !s_q.state[ch]
        && capture_action_t'(c[CAPT_LSB +: 3]) != CAPT_NONE;
      s_d.cap_chan[ch] = c[CHAN_LSB +: 2];
      s_d.cap_act[ch]  = c[CAPT_LSB +: 3];

      set[ch] = cur && !s_q.state[ch];
      set[CH_NUM+ch] = s_d.halt_nr[ch] && !s_q.halt_nr[ch];
    end

    // ***************************************************************
    // Register writes
    // ***************************************************************
    s_d.flag = s_q.flag;
    if (wr_strobe)
    begin
      case (addr)
        CONTROL_OFFSET:
        begin
          s_d.enable = wr_data[ENABLE_BIT];
          s_d.lock   = wr_data[LOCK_BIT];
        end
        IRQ_STATUS_OFFSET:
        begin
          s_d.flag = s_q.flag & ~wr_data[FLAG_W-1:0];
        end
        IRQ_MASK_OFFSET:
        begin
          s_d.mask = wr_data[FLAG_W-1:0];
        end
        FAULT_A_OFFSET:
        begin
          if (wr_fault)
          begin
            s_d.cfg[0] = wr_data & FAULT_WRITE_MASK;
          end
        end
        FAULT_B_OFFSET:
        begin
          if (wr_fault)
          begin
            s_d.cfg[1] = wr_data & FAULT_WRITE_MASK;
          end
        end
        default:
        begin
          s_d.mask = s_q.mask;
        end
      endcase
    end
    s_d.flag = s_d.flag | set;
    s_d.irq  = |(s_d.flag & s_d.mask);

    // ***************************************************************
    // Register reads
    // ***************************************************************
    s_d.rd_data = '0;
    if (rd_strobe)
    begin
      case (addr)
        CONTROL_OFFSET:
        begin
          s_d.rd_data[ENABLE_BIT] = s_q.enable;
          s_d.rd_data[LOCK_BIT]   = s_q.lock;
        end
        IRQ_STATUS_OFFSET:
        begin
          s_d.rd_data[FLAG_W-1:0] = s_q.flag;
        end
        IRQ_MASK_OFFSET:
        begin
          s_d.rd_data[FLAG_W-1:0] = s_q.mask;
        end
        FAULT_A_OFFSET:
        begin
          s_d.rd_data = s_q.cfg[0];
        end
        FAULT_B_OFFSET:
        begin
          s_d.rd_data = s_q.cfg[1];
        end
        default:
        begin
          s_d.rd_data = '0;
        end
      endcase
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign rd_data                = s_q.rd_data;
  assign irq                    = s_q.irq;
  assign fault_state            = s_q.state;
  assign halt_hw                = s_q.halt_hw;
  assign halt_sw                = s_q.halt_sw;
  assign halt_nonrecoverable    = s_q.halt_nr;
  assign restart_pulse          = s_q.restart;
  assign capture_pulse          = s_q.capture;
  assign capture_channel_choice = s_q.cap_chan;
  assign capture_action         = s_q.cap_act;

endmodule : recoverable_fault

// ### sim/fault_event_source.sv
// Event routing model that delivers fault events to the block
`timescale 1ns/10ps
module fault_event_source
#(
  parameter int ROUTE_DELAY = 3
)
(
  input  wire logic [1:0] level_req,
  output logic      [1:0] fault_event_input
);
  initial fault_event_input = 2'h0;
  // Asynchronous routing: edges land off the clock grid
  always @(level_req)
  begin
    fault_event_input <= #(ROUTE_DELAY) level_req;
  end
endmodule : fault_event_source

// ### sim/recoverable_fault_monitor.sv
// Checker of read data, halt levels and fault onset pulses
`timescale 1ns/10ps
module recoverable_fault_monitor
  import fault_cfg_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              wr_strobe,
  input wire logic              rd_strobe,
  input wire logic [31:0]       rd_data,
  input wire logic [1:0]        fault_state,
  input wire logic [1:0]        halt_hw,
  input wire logic [1:0]        halt_sw,
  input wire logic [1:0]        halt_nonrecoverable,
  input wire logic [1:0]        restart_pulse,
  input wire logic [1:0]        capture_pulse,
  input wire logic [3:0]        capture_channel_choice,
  input wire logic [5:0]        capture_action
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_read_idle_zero: assert property (!rd_strobe |=> rd_data == 32'h0)
    else $error("read data not zero outside a read");
  a_reserved_zero:
    assert property (rd_strobe && (addr == FAULT_A_OFFSET ||
      addr == FAULT_B_OFFSET) |=> rd_data[31:28] == 4'h0 && !rd_data[2])
    else $error("reserved bits read non-zero");
  a_halt_needs_fault:
    assert property (((halt_hw | halt_sw | halt_nonrecoverable)
      & ~fault_state) == 2'h0)
    else $error("halt level without fault state");
  a_halt_exclusive:
    assert property (((halt_hw & halt_sw) | (halt_hw & halt_nonrecoverable)
      | (halt_sw & halt_nonrecoverable)) == 2'h0)
    else $error("two halt levels at once");
  a_restart_onset:
    assert property (restart_pulse[0] |-> $rose(fault_state[0]))
    else $error("restart pulse away from fault onset");
  a_restart_single:
    assert property (restart_pulse[0] |=> !restart_pulse[0])
    else $error("restart pulse longer than one cycle");
  a_capture_onset:
    assert property (capture_pulse[1] |-> $rose(fault_state[1])
      && capture_action[5:3] != 3'h0)
    else $error("capture pulse without onset or action");
  a_capture_taken:
    assert property ($rose(fault_state[0]) && capture_action[2:0] != 3'h0
      |-> capture_pulse[0])
    else $error("fault onset missed its capture pulse");
  a_field_after_write:
    assert property ($changed(capture_channel_choice)
      |-> $past(wr_strobe) || $past(wr_strobe, 2))
    else $error("capture channel changed without a write");
endmodule : recoverable_fault_monitor

bind recoverable_fault recoverable_fault_monitor mon_u (.sys_clk(sys_clk),
  .reset(reset), .addr(addr), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
  .rd_data(rd_data), .fault_state(fault_state), .halt_hw(halt_hw),
  .halt_sw(halt_sw), .halt_nonrecoverable(halt_nonrecoverable),
  .restart_pulse(restart_pulse), .capture_pulse(capture_pulse),
  .capture_channel_choice(capture_channel_choice),
  .capture_action(capture_action));

// ### sim/tb_recoverable_fault.sv
// Self-checking bench of the recoverable fault block
`timescale 1ns/10ps
module tb_recoverable_fault;
  import fault_cfg_pkg::*;
  logic              sys_clk = 1'b0;
  logic              reset = 1'b1;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [31:0]       wr_data = 32'h0;
  logic              wr_strobe = 1'b0;
  logic              rd_strobe = 1'b0;
  logic [31:0]       rd_data, q;
  logic              irq, ramp_start = 1'b0, cycle_end = 1'b0;
  logic              timer_tick = 1'b0;
  logic [1:0]        lvl = 2'h0, cmp = 2'h0, ev, fs, hh, hs, hn;
  logic [3:0]        cc;
  logic [5:0]        ca;
  int                n_errors = 0, samples_checked = 0, cyc = 0;
  always #4 sys_clk = ~sys_clk;
  recoverable_fault dut_u (.sys_clk(sys_clk), .reset(reset), .addr(addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .rd_data(rd_data), .irq(irq), .fault_event_input(ev),
    .compare_output_level(cmp), .ramp_start(ramp_start),
    .cycle_end(cycle_end), .timer_tick(timer_tick), .fault_state(fs),
    .halt_hw(hh), .halt_sw(hs), .halt_nonrecoverable(hn),
    .restart_pulse(), .capture_pulse(), .capture_channel_choice(cc),
    .capture_action(ca));
  fault_event_source src_u (.level_req(lvl), .fault_event_input(ev));
  // *****
  // Shared tasks
  // *****
  task automatic chk(input string w, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge sys_clk);
    wr_strobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge sys_clk);
    rd_strobe <= 1'b0;
    #1 q = rd_data;
  endtask : rd
  task automatic setl(input logic [1:0] l, c);
    @(posedge sys_clk);
    lvl <= l;
    cmp <= c;
  endtask : setl
  // Pulse ramp start (0), timer tick (1) or cycle end (2) n times
  task automatic pl(input int k, n);
    repeat (n)
    begin
      @(posedge sys_clk);
      {cycle_end, timer_tick, ramp_start} <= 3'(3'h1 << k);
      @(posedge sys_clk);
      {cycle_end, timer_tick, ramp_start} <= 3'h0;
    end
  endtask : pl
  task automatic fchk(input string w, input logic [1:0] e);
    repeat (8) @(posedge sys_clk);
    #1 chk(w, {30'h0, fs}, {30'h0, e});
  endtask : fchk
  task automatic tally_and_finish;
    $display("mismatches %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // *****
  // Scenarios
  // *****
  task automatic t_regs;
    rd(FAULT_A_OFFSET);
    chk("a reset", q, 32'h0);
    rd(FAULT_B_OFFSET);
    chk("b reset", q, 32'h0);
    wr(FAULT_A_OFFSET, 32'hffff_ffff);
    rd(FAULT_A_OFFSET);
    chk("a fields", q, 32'h0fff_fffb);
    wr(FAULT_B_OFFSET, 32'hffff_ffff);
    rd(FAULT_B_OFFSET);
    chk("b fields", q, 32'h0fff_fffb);
    rd(8'h3c);
    chk("unmapped", q, 32'h0);
    for (int c = 1; c < 4; c++)
    begin
      wr(CONTROL_OFFSET, 32'(c));
      wr(FAULT_A_OFFSET, 32'h0);
      rd(FAULT_A_OFFSET);
      chk("protected", q, 32'h0fff_fffb);
    end
    wr(CONTROL_OFFSET, 32'h0);
    wr(FAULT_A_OFFSET, 32'h0);
    wr(FAULT_B_OFFSET, 32'h0);
  endtask : t_regs
  task automatic t_src;
    for (int h = 1; h < 4; h++)
    begin
      wr(FAULT_A_OFFSET, 32'h0000_1081 | 32'(h << HALT_LSB));
      setl(2'h1, 2'h0);
      fchk("event source", 2'h1);
      chk("halt", {29'h0, hn[0], hs[0], hh[0]}, 32'(1 << (h - 1)));
      setl(2'h0, 2'h0);
      fchk("released", 2'h0);
    end
    wr(FAULT_A_OFFSET, 32'h2);
    fchk("inverted idle", 2'h1);
    setl(2'h3, 2'h0);
    fchk("inverted high", 2'h0);
    wr(FAULT_A_OFFSET, 32'h0);
    wr(FAULT_B_OFFSET, 32'h0000_1001);
    fchk("source off", 2'h2);
    wr(FAULT_A_OFFSET, 32'h3);
    pl(2, 1);
    setl(2'h0, 2'h0);
    fchk("other channel", 2'h1);
    pl(2, 1);
    fchk("other next", 2'h0);
    wr(FAULT_B_OFFSET, 32'h0);
  endtask : t_src
  task automatic t_output_level_gating_keep;
    wr(FAULT_A_OFFSET, 32'h11);
    setl(2'h1, 2'h0);
    fchk("gated", 2'h0);
    setl(2'h1, 2'h1);
    fchk("ungated", 2'h1);
    wr(FAULT_A_OFFSET, 32'h9);
    setl(2'h0, 2'h0);
    fchk("kept", 2'h1);
    pl(2, 1);
    fchk("cycle end release", 2'h0);
  endtask : t_output_level_gating_keep
  // Compare level goes c0 -> c1 as the event rises, to start edge modes
  task automatic t_mask(input logic [31:0] cfg, input int n,
                        input logic [1:0] c0, c1);
    wr(FAULT_A_OFFSET, cfg);
    setl(2'h0, c0);
    pl(0, 1);
    setl(2'h1, c1);
    pl(1, n - 1);
    fchk("masked", 2'h0);
    pl(1, 1);
    fchk("unmasked", 2'h1);
    setl(2'h0, 2'h0);
  endtask : t_mask
  task automatic t_irq_fields;
    wr(IRQ_STATUS_OFFSET, 32'hf);
    wr(IRQ_MASK_OFFSET, 32'h1);
    wr(FAULT_A_OFFSET, 32'h1);
    setl(2'h1, 2'h0);
    fchk("onset", 2'h1);
    chk("irq on", {31'h0, irq}, 32'h1);
    wr(IRQ_STATUS_OFFSET, 32'h1);
    rd(IRQ_STATUS_OFFSET);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(IRQ_MASK_OFFSET, 32'h0);
    setl(2'h0, 2'h0);
    fchk("off", 2'h0);
    setl(2'h1, 2'h0);
    fchk("onset again", 2'h1);
    rd(IRQ_STATUS_OFFSET);
    chk("status", q & 32'h1, 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      wr(FAULT_B_OFFSET, 32'((k << CAPT_LSB) | ((k & 3) << CHAN_LSB)));
      rd(FAULT_B_OFFSET);
      chk("action", {26'h0, ca}, 32'(k << 3));
      chk("channel", {28'h0, cc}, 32'((k & 3) << 2));
    end
  endtask : t_irq_fields
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    t_src();
    t_output_level_gating_keep();
    t_mask(32'h0002_0001, 2, 2'h0, 2'h0);
    t_mask(32'h0002_0021, 2, 2'h0, 2'h1);
    t_mask(32'h0003_0061, 3, 2'h0, 2'h1);
    t_mask(32'h0002_0041, 2, 2'h1, 2'h0);
    t_mask(32'h0001_8001, 64, 2'h0, 2'h0);
    t_irq_fields();
    tally_and_finish();
  end
endmodule : tb_recoverable_fault
